// file: tx_modulation_data_source.sv
// top: transmit modulation data source, clock source, fifo mode exit control
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - data source 00 gpio pin, 10 fifo, 11 pseudorandom sequence
// - source 01 takes bits from serial input only while select is high
// - modulation control holds clock, source, invert, deviation msb, type; resets 23h
// - one access register reads receive fifo and writes transmit fifo, bursts allowed
// - fifo mode leaves transmit or receive on packet sent or valid packet
// - transmit plus tune: send whole fifo, flag sent, drop transmit, stay tuned
// - transmit alone: return to idle after packet sent
// - receive-on clears only on a valid packet, never on errors
// - crc, header, sync errors interrupt but receive continues
// - direct mode bypasses fifos, modulates each bit as it arrives
// - direct gfsk needs a transmit data clock; fsk needs only data
// - clock source 00 none, 01 gpio pin, 11 interrupt pin
// - clock source 10 drives serial output only while select is high
// - invert bit flips transmit data polarity, for test
// - pseudorandom mode makes bits internally from a nine stage generator
// - asynchronous direct mode has no clock and works with fsk only
// - type 00 carrier, 01 ook, 10 fsk, 11 gfsk
module tx_modulation_data_source #(
  parameter int DEPTH = 64
) (
  input  wire logic                  CLK,          // 20 MHz clock
  input  wire logic                  RST_N,        // async reset, active low
  input  wire logic [6:0]            ADDR,         // register address
  input  wire logic [7:0]            WDATA,        // write data
  input  wire logic                  WR,           // write strobe
  input  wire logic                  RD,           // read strobe
  output logic      [7:0]            RDATA,        // read data, cycle after RD
  input  wire logic                  GPIO_DATA,    // direct data pin
  input  wire logic                  SDI,          // serial input pin
  input  wire logic                  SEL_N,        // serial_select_n pin
  output logic                       SDO,          // serial output value
  output logic                       SDO_OE,       // serial output enable
  output logic                       GPIO_CLK,     // data clock on gpio pin
  output logic                       INT_N,        // interrupt_out_n pin
  output logic                       IRQ,          // interrupt level, active high
  input  wire logic [7:0]            RX_BYTE,      // demodulated byte
  input  wire logic                  RX_BYTE_VLD,  // byte strobe
  input  wire txmod_pkg::rx_event_type RX_EVT,     // receive packet events
  output logic                       TX_DATA,      // bit to modulator
  output logic [1:0]                 MOD_KIND,     // modulation type
  output logic                       DEV_MSB,      // deviation_field msb
  output logic                       TX_ON,        // transmitting
  output logic                       RX_ON         // receiving
);

  localparam int AW = $clog2(DEPTH);

  // pin synchronisers
  logic [2:0] pin_meta_q;
  logic [2:0] pin_q;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_meta_q <= 3'h6;
      pin_q      <= 3'h6;
    end else begin
      pin_meta_q <= {SEL_N, SDI, GPIO_DATA};
      pin_q      <= pin_meta_q;
    end
  end
  logic gpio_s;
  logic sdi_s;
  logic sel_high;
  assign gpio_s   = pin_q[0];
  assign sdi_s    = pin_q[1];
  assign sel_high = pin_q[2];

  // register file
  txmod_pkg::mod_ctrl_type mod_q;
  logic [7:0]              opm_q;
  logic [15:0]             rate_q;
  logic [txmod_pkg::ST_W-1:0] status_q;
  logic [txmod_pkg::ST_W-1:0] status_d;
  logic [txmod_pkg::ST_W-1:0] mask_q;
  logic wr_opm;
  logic pkt_sent;
  logic fifo_mode;
  assign wr_opm    = WR && ADDR == txmod_pkg::OFS_OPMODE;
  assign fifo_mode = mod_q.data_src == txmod_pkg::src_fifo;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mod_q  <= txmod_pkg::MODCTL_RST;
      rate_q <= {txmod_pkg::RATE_HI_RST, txmod_pkg::RATE_LO_RST};
      mask_q <= '0;
    end else if (WR) begin
      case (ADDR)
        txmod_pkg::OFS_MODCTL:  mod_q <= WDATA;
        txmod_pkg::OFS_RATE_HI: rate_q[15:8] <= WDATA;
        txmod_pkg::OFS_RATE_LO: rate_q[7:0] <= WDATA;
        txmod_pkg::OFS_MASK:    mask_q <= WDATA[txmod_pkg::ST_W-1:0];
        default: ;
      endcase
    end
  end

  // operating mode: a host write wins over the automatic exits
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      opm_q <= txmod_pkg::OPMODE_RST;
    end else if (wr_opm) begin
      opm_q <= WDATA;
    end else begin
      if (fifo_mode && pkt_sent) begin
        opm_q[txmod_pkg::TXON_BIT] <= 1'b0;
      end
      if (fifo_mode && RX_EVT.pkt_valid && opm_q[txmod_pkg::RXON_BIT]) begin
        opm_q[txmod_pkg::RXON_BIT] <= 1'b0;
      end
    end
  end

  logic tx_on;
  logic rx_on;
  assign tx_on = opm_q[txmod_pkg::TXON_BIT];
  assign rx_on = opm_q[txmod_pkg::RXON_BIT];

  // sticky status, set wins over write-one-clear
  always_comb begin
    status_d = status_q;
    if (WR && ADDR == txmod_pkg::OFS_STATUS) begin
      status_d = status_q & ~WDATA[txmod_pkg::ST_W-1:0];
    end
    if (pkt_sent) begin
      status_d[txmod_pkg::ST_SENT] = 1'b1;
    end
    if (rx_on) begin
      status_d[txmod_pkg::ST_VALID] = status_d[txmod_pkg::ST_VALID] | RX_EVT.pkt_valid;
      status_d[txmod_pkg::ST_CRC]   = status_d[txmod_pkg::ST_CRC] | RX_EVT.crc_err;
      status_d[txmod_pkg::ST_HDR]   = status_d[txmod_pkg::ST_HDR] | RX_EVT.hdr_err;
      status_d[txmod_pkg::ST_SYNC]  = status_d[txmod_pkg::ST_SYNC] | RX_EVT.sync_err;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  // transmit fifo, written through the access register
  logic [7:0]  txm [DEPTH];
  logic [AW:0] tx_wp_q;
  logic [AW:0] tx_rp_q;
  logic        tx_empty;
  logic        tx_full;
  logic        tx_pop;
  assign tx_empty = tx_wp_q == tx_rp_q;
  assign tx_full  = tx_wp_q == {~tx_rp_q[AW], tx_rp_q[AW-1:0]};

  always_ff @(posedge CLK) begin
    if (WR && ADDR == txmod_pkg::OFS_FIFO && !tx_full) begin
      txm[tx_wp_q[AW-1:0]] <= WDATA;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_wp_q <= '0;
      tx_rp_q <= '0;
    end else begin
      if (WR && ADDR == txmod_pkg::OFS_FIFO && !tx_full) begin
        tx_wp_q <= tx_wp_q + 1'b1;
      end
      if (tx_pop) begin
        tx_rp_q <= tx_rp_q + 1'b1;
      end
    end
  end

  // receive fifo, read through the access register
  logic [7:0]  rxm [DEPTH];
  logic [AW:0] rx_wp_q;
  logic [AW:0] rx_rp_q;
  logic        rx_empty;
  logic        rx_full;
  logic        rx_pop;
  assign rx_empty = rx_wp_q == rx_rp_q;
  assign rx_full  = rx_wp_q == {~rx_rp_q[AW], rx_rp_q[AW-1:0]};
  assign rx_pop   = RD && ADDR == txmod_pkg::OFS_FIFO && !rx_empty;

  always_ff @(posedge CLK) begin
    if (RX_BYTE_VLD && rx_on && fifo_mode && !rx_full) begin
      rxm[rx_wp_q[AW-1:0]] <= RX_BYTE;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_wp_q <= '0;
      rx_rp_q <= '0;
    end else begin
      if (RX_BYTE_VLD && rx_on && fifo_mode && !rx_full) begin
        rx_wp_q <= rx_wp_q + 1'b1;
      end
      if (rx_pop) begin
        rx_rp_q <= rx_rp_q + 1'b1;
      end
    end
  end

  // read port
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        txmod_pkg::OFS_MODCTL:  RDATA <= mod_q;
        txmod_pkg::OFS_OPMODE:  RDATA <= opm_q;
        txmod_pkg::OFS_RATE_HI: RDATA <= rate_q[15:8];
        txmod_pkg::OFS_RATE_LO: RDATA <= rate_q[7:0];
        txmod_pkg::OFS_STATUS:  RDATA <= {3'h0, status_q};
        txmod_pkg::OFS_MASK:    RDATA <= {3'h0, mask_q};
        txmod_pkg::OFS_FIFO:    RDATA <= rx_empty ? 8'h00 : rxm[rx_rp_q[AW-1:0]];
        default:                RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // bit period from the rate setting, phase accumulator
  logic [txmod_pkg::ACC_W-1:0] acc_q;
  logic [txmod_pkg::ACC_W-1:0] acc_sum;
  logic                        tick;
  assign acc_sum = acc_q + txmod_pkg::ACC_W'(rate_q);
  assign tick    = tx_on && acc_sum >= txmod_pkg::RATE_MOD;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_q <= '0;
    end else if (!tx_on) begin
      acc_q <= '0;
    end else if (tick) begin
      acc_q <= acc_sum - txmod_pkg::RATE_MOD;
    end else begin
      acc_q <= acc_sum;
    end
  end

  // fifo serialiser, msb first
  logic [7:0] shift_q;
  logic [3:0] left_q;
  logic       fifo_bit_q;
  logic       fifo_bit_d;
  logic       fifo_tick;
  assign fifo_tick = tick && fifo_mode;

  // bit due from this tick on, so the modulator sees the first bit on the loading tick
  always_comb begin
    fifo_bit_d = fifo_bit_q;
    if (left_q != 4'h0) begin
      fifo_bit_d = shift_q[7];
    end else if (!tx_empty) begin
      fifo_bit_d = txm[tx_rp_q[AW-1:0]][7];
    end
  end
  assign tx_pop    = fifo_tick && left_q == 4'h0 && !tx_empty;
  assign pkt_sent  = fifo_tick && left_q == 4'h0 && tx_empty;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      shift_q    <= 8'h00;
      left_q     <= 4'h0;
      fifo_bit_q <= 1'b0;
    end else if (fifo_tick) begin
      if (left_q != 4'h0) begin
        fifo_bit_q <= shift_q[7];
        shift_q    <= {shift_q[6:0], 1'b0};
        left_q     <= left_q - 4'h1;
      end else if (!tx_empty) begin
        fifo_bit_q <= txm[tx_rp_q[AW-1:0]][7];
        shift_q    <= {txm[tx_rp_q[AW-1:0]][6:0], 1'b0};
        left_q     <= 4'h7;
      end
    end
  end

  // pseudorandom generator
  logic [8:0] prbs_q;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prbs_q <= txmod_pkg::PRBS_SEED;
    end else if (tick && mod_q.data_src == txmod_pkg::src_prbs) begin
      prbs_q <= {prbs_q[7:0], prbs_q[8] ^ prbs_q[4]};
    end
  end

  // source selection
  logic direct_bit;
  logic sdi_hold_q;
  logic async_mode;
  logic src_bit;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sdi_hold_q <= 1'b0;
    end else if (sel_high) begin
      sdi_hold_q <= sdi_s;
    end
  end

  assign direct_bit = mod_q.data_src == txmod_pkg::src_sdi
                      ? (sel_high ? sdi_s : sdi_hold_q)
                      : gpio_s;
  assign async_mode = mod_q.clk_src == txmod_pkg::clk_none
                      && mod_q.mod_kind == txmod_pkg::mod_fsk;

  always_comb begin
    case (mod_q.data_src)
      txmod_pkg::src_gpio: src_bit = direct_bit;
      txmod_pkg::src_sdi:  src_bit = direct_bit;
      txmod_pkg::src_fifo: src_bit = fifo_bit_d;
      txmod_pkg::src_prbs: src_bit = prbs_q[8];
      default:             src_bit = 1'b0;
    endcase
  end

  // modulator bit: direct async follows the pin, direct without clock and not fsk drives 0, otherwise sampled per bit period
  logic direct_mode;
  assign direct_mode = !mod_q.data_src[1];
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      TX_DATA <= 1'b0;
    end else if (!tx_on) begin
      TX_DATA <= 1'b0;
    end else if (direct_mode && async_mode) begin
      TX_DATA <= direct_bit ^ mod_q.invert;
    end else if (direct_mode && mod_q.clk_src == txmod_pkg::clk_none) begin
      TX_DATA <= 1'b0;
    end else if (tick) begin
      TX_DATA <= src_bit ^ mod_q.invert;
    end
  end

  // transmit data clock, high in the first half of each bit period
  logic tclk;
  assign tclk = tx_on && direct_mode && acc_q < txmod_pkg::RATE_HALF;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      GPIO_CLK <= 1'b0;
      SDO      <= 1'b0;
      SDO_OE   <= 1'b0;
      INT_N    <= 1'b1;
      IRQ      <= 1'b0;
    end else begin
      GPIO_CLK <= mod_q.clk_src == txmod_pkg::clk_gpio && tclk;
      SDO      <= tclk;
      SDO_OE   <= mod_q.clk_src == txmod_pkg::clk_sdo && sel_high;
      IRQ      <= |(status_q & mask_q);
      if (mod_q.clk_src == txmod_pkg::clk_irq) begin
        INT_N <= ~tclk;
      end else begin
        INT_N <= ~|(status_q & mask_q);
      end
    end
  end

  // status outputs
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      MOD_KIND <= 2'h0;
      DEV_MSB  <= 1'b0;
      TX_ON    <= 1'b0;
      RX_ON    <= 1'b0;
    end else begin
      MOD_KIND <= mod_q.mod_kind;
      DEV_MSB  <= mod_q.deviation_field;
      TX_ON    <= tx_on;
      RX_ON    <= rx_on;
    end
  end

endmodule // tx_modulation_data_source

// file: txmod_pkg.sv
// package: register map, field layouts and timing for the transmit data source block
package txmod_pkg;

  // register offsets
  localparam logic [6:0] OFS_STATUS  = 7'h03;
  localparam logic [6:0] OFS_MASK    = 7'h05;
  localparam logic [6:0] OFS_OPMODE  = 7'h07;
  localparam logic [6:0] OFS_RATE_HI = 7'h6e;
  localparam logic [6:0] OFS_RATE_LO = 7'h6f;
  localparam logic [6:0] OFS_MODCTL  = 7'h71;
  localparam logic [6:0] OFS_FIFO    = 7'h7f;

  // values after reset
  localparam logic [7:0] MODCTL_RST  = 8'h23;
  localparam logic [7:0] RATE_HI_RST = 8'h0a;
  localparam logic [7:0] RATE_LO_RST = 8'haa;
  localparam logic [7:0] OPMODE_RST  = 8'h00;
  localparam logic [8:0] PRBS_SEED   = 9'h1ff;

  // operating mode bit positions
  localparam int PLLON_BIT = 1;
  localparam int RXON_BIT  = 2;
  localparam int TXON_BIT  = 3;

  // status and mask bit positions
  localparam int ST_W     = 5;
  localparam int ST_SENT  = 0;
  localparam int ST_VALID = 1;
  localparam int ST_CRC   = 2;
  localparam int ST_HDR   = 3;
  localparam int ST_SYNC  = 4;

  // bit rate: rate = setting * 1 MHz / 2^16, phase step per 50 ns clock
  localparam int CLK_HZ  = 20_000_000;
  localparam int REF_HZ  = 1_000_000;
  localparam int ACC_W   = 21;
  localparam logic [ACC_W-1:0] RATE_MOD = ACC_W'((CLK_HZ / REF_HZ) * 65536);
  localparam logic [ACC_W-1:0] RATE_HALF = ACC_W'((CLK_HZ / REF_HZ) * 32768);

  typedef enum logic [1:0] {
    src_gpio = 2'b00, src_sdi = 2'b01, src_fifo = 2'b10, src_prbs = 2'b11
  } data_src_type;

  typedef enum logic [1:0] {
    clk_none = 2'b00, clk_gpio = 2'b01, clk_sdo = 2'b10, clk_irq = 2'b11
  } clk_src_type;

  typedef enum logic [1:0] {
    mod_carrier = 2'b00, mod_ook = 2'b01, mod_fsk = 2'b10, mod_gfsk = 2'b11
  } mod_kind_type;

  typedef struct packed {
    clk_src_type  clk_src;
    data_src_type data_src;
    logic         invert;
    logic         deviation_field;
    mod_kind_type mod_kind;
  } mod_ctrl_type;

  typedef struct packed {
    logic pkt_valid;
    logic crc_err;
    logic hdr_err;
    logic sync_err;
  } rx_event_type;

endpackage

// file: txmod_props.sv
// assertions on the ports of the transmit data source block
`timescale 1ns/1ps
module txmod_props (
  input wire logic                    CLK,      // clock
  input wire logic                    RST_N,    // reset
  input wire logic [6:0]              ADDR,     // address
  input wire logic                    WR,       // write
  input wire logic                    RD,       // read
  input wire logic [7:0]              WDATA,    // write data
  input wire logic [7:0]              RDATA,    // read data
  input wire logic                    SEL_N,    // select pin
  input wire logic                    SDO_OE,   // sdo enable
  input wire logic                    IRQ,      // interrupt
  input wire txmod_pkg::rx_event_type RX_EVT,   // rx events
  input wire logic                    TX_DATA,  // tx bit
  input wire logic [1:0]              MOD_KIND, // mod type
  input wire logic                    DEV_MSB,  // deviation msb
  input wire logic                    TX_ON,    // tx on
  input wire logic                    RX_ON     // rx on
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // cycles since the last write or valid packet, saturating
  logic [1:0] calm_q;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) calm_q <= 2'h0;
    else if (WR || RX_EVT.pkt_valid) calm_q <= 2'h0;
    else if (calm_q != 2'h3) calm_q <= calm_q + 2'h1;
  end
  property p_rd_slot; !$past(RD) |-> RDATA == 8'h00; endproperty
  a_rd_slot: assert property (p_rd_slot) else $error("read data outside slot");
  property p_rd_hole; (RD && ADDR == 7'h10) |=> RDATA == 8'h00; endproperty
  a_rd_hole: assert property (p_rd_hole) else $error("unmapped read not zero");
  property p_mod_cause;
    ($changed({MOD_KIND, DEV_MSB}) && $past(RST_N, 2)) |->
      ($past(WR, 2) && $past(ADDR, 2) == txmod_pkg::OFS_MODCTL) ||
      ($past(WR) && $past(ADDR) == txmod_pkg::OFS_MODCTL);
  endproperty
  a_mod_cause: assert property (p_mod_cause) else $error("mod type moved alone");
  property p_off_zero; (!TX_ON && !$past(TX_ON) && !$past(TX_ON, 2)) |-> !TX_DATA; endproperty
  a_off_zero: assert property (p_off_zero) else $error("tx bit while off");
  property p_sel_low; (!SEL_N) [*6] |-> !SDO_OE; endproperty
  a_sel_low: assert property (p_sel_low) else $error("sdo driven, select low");
  property p_rx_hold; (calm_q == 2'h3 && RX_ON) |=> RX_ON; endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx dropped alone");
  property p_irq_hold; (calm_q == 2'h3 && IRQ) |=> IRQ; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq fell alone");
  property p_opmode_wr;
    (WR && ADDR == txmod_pkg::OFS_OPMODE) |-> ##2 {TX_ON, RX_ON} == $past(WDATA[3:2], 2);
  endproperty
  a_opmode_wr: assert property (p_opmode_wr) else $error("mode bits wrong");
  c_valid: cover property (RX_ON ##1 RX_EVT.pkt_valid);
  c_irq: cover property ($rose(IRQ));
  c_oe: cover property ($rose(SDO_OE));
endmodule // txmod_props

// file: host_pin_model.sv
// host model: shifts a bit pattern onto the direct data pins
`timescale 1ns/1ps
module host_pin_model (
  input  wire logic        run,       // send while high
  input  wire logic [15:0] pattern,   // bits, msb first
  output logic             gpio_data, // data pin
  output logic             sdi        // serial input pin
);
  logic       lclk;
  logic [3:0] idx = 4'hf;
  logic       gpio_q = 1'b0;
  logic       sdi_q = 1'b1;
  assign gpio_data = gpio_q;
  assign sdi       = sdi_q;
  // link clock stands still outside a frame
  initial begin
    lclk = 1'b0;
    #37;
    forever #200 lclk = run ? ~lclk : 1'b0;
  end
  always @(posedge lclk) begin
    gpio_q <= pattern[idx];
    sdi_q <= pattern[idx];
    idx <= idx - 4'h1;
  end
endmodule // host_pin_model

// file: tx_modulation_data_source_test.sv
// self-checking bench for the transmit data source block
`timescale 1ns/1ps
module tx_modulation_data_source_test;
  logic                    clk, rst_n, wr_s, rd_s, sel_n, vld, run;
  logic                    gpio, sdi, sdo, sdo_oe, gclk, int_n, irq, txd, tx_on, rx_on, dev;
  logic [1:0]              kind;
  logic [2:0]              dclk, p;
  logic [6:0]              addr;
  logic [7:0]              wdata, rdata, hist, v;
  txmod_pkg::rx_event_type evt;
  int                      fails = 0;
  int                      n_checks = 0;
  int                      n;
  logic                    bits [24];
  assign dclk = {int_n, sdo, gclk};
  tx_modulation_data_source tx_modulation_data_source_inst (
    .CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .GPIO_DATA(gpio), .SDI(sdi), .SEL_N(sel_n), .SDO(sdo), .SDO_OE(sdo_oe),
    .GPIO_CLK(gclk), .INT_N(int_n), .IRQ(irq), .RX_BYTE(8'h3c), .RX_BYTE_VLD(vld),
    .RX_EVT(evt), .TX_DATA(txd), .MOD_KIND(kind), .DEV_MSB(dev), .TX_ON(tx_on), .RX_ON(rx_on));
  host_pin_model host_pin_model_inst (
    .run(run), .pattern(16'hb4c6), .gpio_data(gpio), .sdi(sdi));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) hist <= {hist[6:0], gpio};
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask
  task automatic grab(input int per);
    repeat (per + per / 2) @(posedge clk);
    for (int i = 0; i < 24; i++) begin
      bits[i] = txd;
      repeat (per) @(posedge clk);
    end
  endtask
  // compare the tx bit with the pin once the pin has been steady
  task automatic follow;
    for (int i = 0; i < 24; i++) begin
      repeat (8) @(negedge clk);
      if (hist[7:2] == 6'h00 || hist[7:2] == 6'h3f) chk({7'h00, txd}, {7'h00, hist[2]});
    end
  endtask
  task automatic t_regs;
    rdc(txmod_pkg::OFS_MODCTL, 8'h23);
    rdc(7'h6e, 8'h0a);
    rdc(7'h10, 8'h00);
    wr(txmod_pkg::OFS_MODCTL, 8'h5a);
    rdc(txmod_pkg::OFS_MODCTL, 8'h5a);
    for (int k = 0; k < 4; k++) begin
      wr(txmod_pkg::OFS_MODCTL, 8'(k * 5));
      repeat (2) @(negedge clk);
      chk({5'h00, dev, kind}, 8'(k * 5 & 7));
    end
    $display("done regs");
  endtask
  task automatic t_tx;
    wr(7'h6e, 8'h20);
    wr(7'h6f, 8'h00);
    wr(txmod_pkg::OFS_MASK, 8'h1f);
    wr(txmod_pkg::OFS_MODCTL, 8'h22);
    wr(txmod_pkg::OFS_FIFO, 8'ha5);
    wr(txmod_pkg::OFS_OPMODE, 8'h0a);
    grab(160);
    for (int i = 0; i < 8; i++) v = {v[6:0], bits[i]};
    chk(v, 8'ha5);
    rdc(txmod_pkg::OFS_OPMODE, 8'h02);
    rdc(txmod_pkg::OFS_STATUS, 8'h01);
    chk({7'h00, irq}, 8'h01);
    chk({7'h00, int_n}, 8'h00);
    wr(txmod_pkg::OFS_STATUS, 8'h01);
    repeat (2) @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    chk({7'h00, int_n}, 8'h01);
    $display("done fifo tx");
  endtask
  task automatic t_idle;
    wr(txmod_pkg::OFS_OPMODE, 8'h08);
    repeat (200) @(posedge clk);
    rdc(txmod_pkg::OFS_OPMODE, 8'h00);
    rdc(txmod_pkg::OFS_STATUS, 8'h01);
    wr(txmod_pkg::OFS_STATUS, 8'h01);
    $display("done idle");
  endtask
  // each bit is the xor of the bits nine and five places back
  task automatic t_prbs(input logic inv);
    wr(txmod_pkg::OFS_MODCTL, inv ? 8'h3a : 8'h32);
    wr(txmod_pkg::OFS_OPMODE, 8'h08);
    grab(160);
    wr(txmod_pkg::OFS_OPMODE, 8'h00);
    for (int i = 0; i < 15; i++) chk({7'h00, bits[i + 9] ^ bits[i + 4] ^ bits[i]}, {7'h00, inv});
    $display("done prbs");
  endtask
  task automatic t_rx;
    wr(txmod_pkg::OFS_MODCTL, 8'h22);
    wr(txmod_pkg::OFS_OPMODE, 8'h04);
    @(posedge clk);
    vld <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      vld <= 1'b0;
      evt <= txmod_pkg::rx_event_type'(4'h1 << i);
      @(posedge clk);
      evt <= '0;
      repeat (3) @(negedge clk);
      chk({7'h00, rx_on}, {7'h00, i != 3});
    end
    rdc(txmod_pkg::OFS_STATUS, 8'h1e);
    chk({7'h00, irq}, 8'h01);
    wr(txmod_pkg::OFS_MASK, 8'h00);
    repeat (2) @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    rdc(txmod_pkg::OFS_FIFO, 8'h3c);
    rdc(txmod_pkg::OFS_FIFO, 8'h00);
    wr(txmod_pkg::OFS_STATUS, 8'h1f);
    $display("done rx");
  endtask
  task automatic t_direct;
    wr(7'h6e, 8'hff);
    wr(7'h6f, 8'hff);
    wr(txmod_pkg::OFS_MODCTL, 8'h02);
    run <= 1'b1;
    wr(txmod_pkg::OFS_OPMODE, 8'h08);
    follow;
    wr(txmod_pkg::OFS_MODCTL, 8'h12);
    follow;
    @(posedge clk);
    sel_n <= 1'b0;
    repeat (10) @(negedge clk);
    v[0] = txd;
    repeat (40) @(negedge clk);
    chk({7'h00, txd}, {7'h00, v[0]});
    @(posedge clk);
    sel_n <= 1'b1;
    wr(txmod_pkg::OFS_MODCTL, 8'h03);
    for (int i = 0; i < 3; i++) begin
      repeat (20) @(negedge clk);
      chk({7'h00, txd}, 8'h00);
    end
    for (int c = 1; c < 4; c++) begin
      wr(txmod_pkg::OFS_MODCTL, {2'(c), 6'h03});
      n = 0;
      p = dclk;
      repeat (100) begin
        @(negedge clk);
        if (dclk[c - 1] != p[c - 1]) n++;
        p = dclk;
      end
      chk({7'h00, n > 4}, 8'h01);
      if (c == 2) chk({7'h00, sdo_oe}, 8'h01);
    end
    wr(txmod_pkg::OFS_MODCTL, 8'h83);
    sel_n <= 1'b0;
    repeat (10) @(negedge clk);
    chk({7'h00, sdo_oe}, 8'h00);
    wr(txmod_pkg::OFS_OPMODE, 8'h00);
    run <= 1'b0;
    $display("done direct");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {rst_n, wr_s, rd_s, vld, run, sel_n} = 6'h01;
    addr = 7'h00;
    wdata = 8'h00;
    evt = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_tx;
    t_idle;
    t_prbs(1'b0);
    t_prbs(1'b1);
    t_rx;
    t_direct;
    summarize;
  end
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    summarize;
  end
endmodule // tx_modulation_data_source_test
bind tx_modulation_data_source txmod_props txmod_props_inst (
  .CLK, .RST_N, .ADDR, .WR, .RD, .WDATA, .RDATA, .SEL_N, .SDO_OE, .IRQ, .RX_EVT,
  .TX_DATA, .MOD_KIND, .DEV_MSB, .TX_ON, .RX_ON);
